// *** bench/mcec_checker_top_bench.sv ***
// Self-checking bench for the motion command error checker
`timescale 1ns/1ps
`default_nettype none
module mcec_checker_top_bench;
  localparam logic [31:0] BIG = 32'h4000_0000;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_valid_i, cmd_ready_o;
  logic        cmd_comm_err_i, rsp_valid_o, exec_valid_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, cmd_arg_a_i, cmd_arg_b_i;
  logic [5:0]  cmd_op_i;
  logic [1:0]  cmd_axis_i;
  logic [3:0]  rsp_code_o;
  logic [10:0] st_q;
  int          n_fail, cmp_count;
  mcec_host_model i_mcec_host_model (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i),
    .cmd_op_o(cmd_op_i), .cmd_axis_o(cmd_axis_i), .cmd_arg_a_o(cmd_arg_a_i),
    .cmd_arg_b_o(cmd_arg_b_i), .cmd_comm_err_o(cmd_comm_err_i));
  mcec_checker_top i_mcec_checker_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_axis_i(cmd_axis_i),
    .cmd_arg_a_i(cmd_arg_a_i), .cmd_arg_b_i(cmd_arg_b_i), .cmd_comm_err_i(cmd_comm_err_i),
    .ax_active_i(st_q[0]), .ax_moving_i(st_q[1]), .ax_gear_i(st_q[2]), .ax_jog_i(st_q[3]),
    .ax_capt_done_i(st_q[4]), .ax_drv_alarm_i(st_q[5]), .frozen_change_i(st_q[6]),
    .buf_exec_i(st_q[7]), .list_closed_i(st_q[8]), .seg_busy_i(st_q[9]),
    .buf_full_i(st_q[10]), .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o),
    .exec_valid_o(exec_valid_o), .exec_op_o(), .exec_axis_o(), .exec_arg_a_o(),
    .exec_arg_b_o(), .crd_illegal_o(), .axis_illegal_o(), .intr_enable_o());
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 20)
    begin
      n_fail++;
      test_done();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask
  // st: [10:0] state, [11] intr enable, [12] comm fault
  task automatic row(input logic [5:0] op, input logic [31:0] a, input logic [12:0] st,
                     input logic [3:0] code, input logic [15:0] cause);
    wr(mcec_pkg::ADDR_CTRL, {29'h0, 2'h3, st[11]});
    st_q <= st[10:0];
    i_mcec_host_model.send(op, a, st[12]);
    #1;
    chk({rsp_valid_o, exec_valid_o, rsp_code_o}, {1'b1, code == 4'h0, code});
    rd(mcec_pkg::ADDR_CAUSE, {16'h0, cause});
    rd(mcec_pkg::ADDR_STATUS, {20'h0, code, code == 4'h1 && cause[15:12] == 4'h0, 3'h0,
      code == 4'h1 && cause[15:12] != 4'h0, 3'h0});
  endtask
  task automatic check_reset();
    rd(mcec_pkg::ADDR_CAUSE, 32'h0);
    rd(mcec_pkg::ADDR_CTRL, 32'h0);
    rd(mcec_pkg::ADDR_STATUS, 32'h0);
    rd(mcec_pkg::ADDR_BOUND, mcec_pkg::BOUND_RST);
    rd(mcec_pkg::ADDR_MAP, 32'h0);
    wr(mcec_pkg::ADDR_CAUSE, 32'h0000_FFFF);
    rd(mcec_pkg::ADDR_CAUSE, 32'h0);
    rd(8'h20, 32'h0);
    chk(cmd_ready_o, 1'b1);
  endtask
  task automatic check_codes();
    row(6'h00, 32'h0, 13'h0, 4'h2, 16'h0);
    row(6'h01, BIG, 13'h0, 4'h2, 16'h0);
    row(6'h06, 32'h0, 13'h0, 4'h3, 16'h0);
    row(6'h07, 32'hFFFF_FFFB, 13'h0, 4'h3, 16'h0);
    row(6'h08, BIG, 13'h0, 4'h3, 16'h0);
    row(6'h09, 32'h0, 13'h0, 4'h4, 16'h0);
    row(6'h0A, BIG, 13'h0, 4'h4, 16'h0);
    row(6'h05, 32'h0, 13'h0, 4'h5, 16'h0);
    row(6'h30, 32'h1, 13'h0, 4'h7, 16'h0);
    row(6'h0C, 32'h5, 13'h1000, 4'hF, 16'h0);
    row(6'h06, 32'hA, 13'h0, 4'h0, 16'h0);
  endtask
  task automatic check_causes();
    row(6'h0C, BIG, 13'h0, 4'h1, 16'h0001);
    row(6'h10, 32'hFFFF_FFFF, 13'h0, 4'h1, 16'h0002);
    row(6'h12, 32'h0, 13'h0, 4'h1, 16'h0004);
    row(6'h13, 32'h0, 13'h001, 4'h1, 16'h0008);
    row(6'h14, 32'h0, 13'h0, 4'h1, 16'h0010);
    row(6'h14, 32'h0, 13'h800, 4'h0, 16'h0);
    row(6'h15, 32'h0, 13'h002, 4'h1, 16'h0040);
    row(6'h15, 32'h0, 13'h006, 4'h0, 16'h0);
    row(6'h17, 32'h0, 13'h010, 4'h1, 16'h0100);
    row(6'h18, 32'h0, 13'h020, 4'h1, 16'h0200);
    row(6'h19, 32'h0, 13'h002, 4'h1, 16'h0800);
    row(6'h1A, 32'h0, 13'h042, 4'h1, 16'h0800);
    row(6'h1D, 32'h0, 13'h080, 4'h1, 16'h1000);
    row(6'h1E, 32'h0, 13'h0, 4'h1, 16'h1000);
    row(6'h20, BIG, 13'h0, 4'h1, 16'h2000);
    row(6'h06, 32'hA, 13'h400, 4'h1, 16'h8000);
    row(6'h06, 32'hA, 13'h0, 4'h0, 16'h0);
  endtask
  task automatic check_history();
    row(6'h16, 32'h0, 13'h0, 4'h0, 16'h0);
    row(6'h16, 32'h0, 13'h0, 4'h1, 16'h0080);
    row(6'h0B, 32'h3, 13'h0, 4'h0, 16'h0);
    row(6'h0B, 32'h1, 13'h0, 4'h6, 16'h0);
    rd(mcec_pkg::ADDR_MAP, 32'h3);
    wr(mcec_pkg::ADDR_BOUND, 32'h64);
    row(6'h06, 32'h65, 13'h0, 4'h3, 16'h0);
    row(6'h06, 32'h64, 13'h0, 4'h0, 16'h0);
  endtask
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    st_q = 11'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    check_reset();
    check_codes();
    check_causes();
    check_history();
    test_done();
  end
endmodule // mcec_checker_top_bench
`default_nettype wire

// *** bench/mcec_host_model.sv ***
// Host side model that issues motion commands one strobe at a time
`timescale 1ns/1ps
`default_nettype none
module mcec_host_model
(
  input  wire logic        clk_i,
  output logic             cmd_valid_o,
  output logic      [5:0]  cmd_op_o,
  output logic      [1:0]  cmd_axis_o,
  output logic      [31:0] cmd_arg_a_o,
  output logic      [31:0] cmd_arg_b_o,
  output logic             cmd_comm_err_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 6'h3F;
    cmd_axis_o = 2'h0;
    cmd_arg_a_o = 32'h0;
    cmd_arg_b_o = 32'h0;
    cmd_comm_err_o = 1'b0;
  end
  task automatic send(input logic [5:0] op, input logic [31:0] a, input logic ce);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op;
    cmd_axis_o <= 2'h1;
    cmd_arg_a_o <= a;
    cmd_arg_b_o <= a;
    cmd_comm_err_o <= ce;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    // Released arguments no longer show the last value
    cmd_arg_a_o <= ~a;
    cmd_arg_b_o <= ~a;
    cmd_comm_err_o <= ~ce;
  endtask
endmodule // mcec_host_model
`default_nettype wire

// *** bench/mcec_monitor.sv ***
// Assertions on the command error checker ports
`timescale 1ns/1ps
`default_nettype none
module mcec_monitor
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        cmd_valid_i,
  input wire logic [5:0]  cmd_op_i,
  input wire logic        cmd_comm_err_i,
  input wire logic        ax_active_i,
  input wire logic        ax_drv_alarm_i,
  input wire logic        buf_full_i,
  input wire logic        rsp_valid_o,
  input wire logic [3:0]  rsp_code_o,
  input wire logic        exec_valid_o,
  input wire logic        crd_illegal_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    cmd_valid_i && !cmd_comm_err_i;
  endsequence
  sequence s_refuse;
    rsp_valid_o && rsp_code_o == 4'h1 && !exec_valid_o;
  endsequence
  a_rsp_next: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("no response");
  a_comm_code: assert property (cmd_valid_i && cmd_comm_err_i |=> rsp_code_o == 4'hF)
    else $error("bad comm code");
  a_fault_discard: assert property (rsp_valid_o && rsp_code_o != 4'h0 |-> !exec_valid_o)
    else $error("fault executed");
  a_code_ops: assert property (rsp_valid_o |->
    (rsp_code_o != 4'h2 || $past(cmd_op_i) <= 6'h02) &&
    (rsp_code_o != 4'h3 || $past(cmd_op_i) inside {[6'h06:6'h08]}) &&
    (rsp_code_o != 4'h4 || $past(cmd_op_i) inside {[6'h09:6'h0A]}) &&
    (rsp_code_o != 4'h5 || $past(cmd_op_i) inside {[6'h03:6'h05]}))
    else $error("code on wrong op");
  a_alarm_clear: assert property (s_take ##0 (cmd_op_i == 6'h13 && ax_active_i)
    |=> s_refuse) else $error("alarm clear not refused");
  a_enable_alarm: assert property (s_take ##0 (cmd_op_i == 6'h18 && ax_drv_alarm_i)
    |=> s_refuse) else $error("enable not refused");
  a_buffer_full: assert property (s_take ##0 (cmd_op_i <= 6'h0A && buf_full_i)
    |=> s_refuse ##0 crd_illegal_o) else $error("full buffer not refused");
  a_crd_flag: assert property (rsp_valid_o && rsp_code_o == 4'h1 &&
    $past(cmd_op_i) inside {[6'h00:6'h0B], [6'h1C:6'h21]} |-> crd_illegal_o)
    else $error("coord flag not set");
  a_rsvd_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00
    |-> (wb_dat_o[15:0] & mcec_pkg::CAUSE_RSVD) == 16'h0000) else $error("reserved bit set");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
endmodule // mcec_monitor
bind mcec_checker_top mcec_monitor i_mcec_monitor
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
  .cmd_comm_err_i(cmd_comm_err_i), .ax_active_i(ax_active_i), .ax_drv_alarm_i(ax_drv_alarm_i),
  .buf_full_i(buf_full_i), .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o),
  .exec_valid_o(exec_valid_o), .crd_illegal_o(crd_illegal_o)
);
`default_nettype wire

// *** pkg/mcec_pkg.sv ***
// Constants and types of the motion command error checker
package mcec_pkg;
  localparam logic [7:0] ADDR_CAUSE  = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BOUND  = 8'h0C;
  localparam logic [7:0] ADDR_MAP    = 8'h10;
  localparam int CTRL_INTR_EN   = 0;
  localparam int CTRL_CLR_CAUSE = 1;
  localparam int CTRL_CLR_STS   = 2;
  localparam int STS_CRD_ILL    = 3;
  localparam int STS_AXIS_ILL   = 7;
  localparam int STS_CODE_LSB   = 8;
  localparam int C_OVF    = 0;
  localparam int C_CTRL   = 1;
  localparam int C_MULTI  = 2;
  localparam int C_DRVCLR = 3;
  localparam int C_INTR   = 4;
  localparam int C_MODE   = 6;
  localparam int C_IDX    = 7;
  localparam int C_HOME   = 8;
  localparam int C_ENA    = 9;
  localparam int C_FROZEN = 11;
  localparam int C_CRD    = 12;
  localparam int C_PTP    = 13;
  localparam int C_FULL   = 15;
  localparam logic [15:0] CAUSE_RSVD = 16'h4420;
  localparam logic [15:0] CAUSE_RST  = 16'h0000;
  localparam logic        INTR_EN_RST = 1'b0;
  localparam logic [31:0] BOUND_RST  = 32'h3FFF_FFFF;
  localparam logic [3:0]  MAP_RST    = 4'h0;
  typedef enum logic [3:0] {
    RES_COMM = 4'hF, RES_OK = 4'h0, RES_ILLEGAL = 4'h1, RES_RADIUS = 4'h2,
    RES_LENGTH = 4'h3, RES_VECTOR = 4'h4, RES_ENDPT = 4'h5, RES_MAP = 4'h6,
    RES_PARAM = 4'h7
  } mcec_res_t;
  typedef enum logic [5:0] {
    OP_ARC1_RAD = 6'h00, OP_ARC2_RAD = 6'h01, OP_ARC3_RAD = 6'h02,
    OP_ARC1_END = 6'h03, OP_ARC2_END = 6'h04, OP_ARC3_END = 6'h05,
    OP_LINE2 = 6'h06, OP_LINE3 = 6'h07, OP_LINE4 = 6'h08,
    OP_VEC_VEL = 6'h09, OP_VEC_ACC = 6'h0A, OP_MAP_AXES = 6'h0B,
    OP_SET_POS = 6'h0C, OP_SET_VEL = 6'h0D, OP_SET_ACC = 6'h0E,
    OP_SET_ACTUAL = 6'h0F, OP_SET_JERK = 6'h10, OP_SET_CTRL_PAR = 6'h11,
    OP_MULTI_COMMIT = 6'h12, OP_DRV_ALARM_CLR = 6'h13, OP_INTR_CMD = 6'h14,
    OP_SET_MODE = 6'h15, OP_ARM_INDEX = 6'h16, OP_ARM_HOME = 6'h17,
    OP_AXIS_ENABLE = 6'h18, OP_ZERO_POS = 6'h19, OP_SINGLE_COMMIT = 6'h1A,
    OP_SYNC_POS = 6'h1B, OP_START_MOVE = 6'h1C, OP_START_LIST = 6'h1D,
    OP_APPEND_LIST = 6'h1E, OP_MOVE2 = 6'h1F, OP_MOVE3 = 6'h20,
    OP_MOVE4 = 6'h21
  } mcec_op_t;
endpackage

// *** pkg/mcec_reg_if.sv ***
// Register access path between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface mcec_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [3:0]  sel;
  logic [31:0] rdata;
  modport bus
  (
    output wr, addr, wdata, sel,
    input  rdata
  );
  modport regs
  (
    input  wr, addr, wdata, sel,
    output rdata
  );
endinterface
`default_nettype wire

// *** rtl/mcec_checker_top.sv ***
// Motion command validation, result codes and error cause register
// Function
// RQ1: Answer each command with signed result code
// RQ2: Code 2 only for radius arc commands
// RQ3: Code 3 only for bad line length
// RQ4: Code 4 for bad vector velocity/acceleration
// RQ5: Code 5 for bad endpoint arc commands
// RQ6: Code 6 when axis mapping fails/conflicts
// RQ7: Code 7 for unreasonable general parameters
// RQ8: Illegal commands are discarded, never executed
// RQ9: Illegal sets coordinated bit3 or axis bit7
// RQ10: Host-readable 16-bit cause register, axis/coordinate split
// RQ11: Bit0 on motion parameter overflow
// RQ12: Bit1 on illegal control parameter
// RQ13: Bit2 on multi-axis commit with zero
// RQ14: Bit3 on alarm clear while axis active
// RQ15: Bit4 on interrupt command, interrupts disabled
// RQ16: Bit6 on mode change while moving, except gearing
// RQ17: Bit7/Bit8 on re-arm while capture done/pending
// RQ18: Bit9 on axis enable during drive alarm
// RQ19: Bit11 on frozen change while moving or jog sync
// RQ20: Bit12 on illegal coordinate-system sequencing
// RQ21: Bit13 on point-to-point move errors
// RQ22: Buffer full refuses command, sets Bit15; host retries
// RQ23: Reserved bits 5, 10, 14 read zero
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mcec_checker_top
#(
  parameter int NUM_AXES = 4,
  parameter int AXIS_W   = 2
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire logic [5:0]        cmd_op_i,
  input  wire logic [AXIS_W-1:0] cmd_axis_i,
  input  wire logic [31:0]       cmd_arg_a_i,
  input  wire logic [31:0]       cmd_arg_b_i,
  input  wire logic              cmd_comm_err_i,
  input  wire logic              ax_active_i,
  input  wire logic              ax_moving_i,
  input  wire logic              ax_gear_i,
  input  wire logic              ax_jog_i,
  input  wire logic              ax_capt_done_i,
  input  wire logic              ax_drv_alarm_i,
  input  wire logic              frozen_change_i,
  input  wire logic              buf_exec_i,
  input  wire logic              list_closed_i,
  input  wire logic              seg_busy_i,
  input  wire logic              buf_full_i,
  output logic                   rsp_valid_o,
  output logic      [3:0]        rsp_code_o,
  output logic                   exec_valid_o,
  output logic      [5:0]        exec_op_o,
  output logic      [AXIS_W-1:0] exec_axis_o,
  output logic      [31:0]       exec_arg_a_o,
  output logic      [31:0]       exec_arg_b_o,
  output logic                   crd_illegal_o,
  output logic                   axis_illegal_o,
  output logic                   intr_enable_o
);

  // Magnitude above the motion bound
  function automatic logic over_bound(input logic [31:0] v, input logic [31:0] b);
    logic [31:0] m;
    m = v[31] ? (~v + 32'h0000_0001) : v;
    return m > b;
  endfunction

  // Zero or negative
  function automatic logic non_pos(input logic [31:0] v);
    return v[31] | (v == 32'h0000_0000);
  endfunction

  // Byte-lane merge for writable words
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  mcec_reg_if rif ();

  mcec_wb_slave u_wb
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rif      (rif.bus)
  );

  // Registers
  logic [15:0] cause_q;
  logic [15:0] cause_d;
  logic        intr_en_q;
  logic [31:0] bound_q;
  logic        crd_ill_q;
  logic        axis_ill_q;
  logic [3:0]  last_code_q;
  logic        rsp_valid_q;
  logic [3:0]  rsp_code_q;
  logic        exec_valid_q;
  logic [5:0]  exec_op_q;
  logic [AXIS_W-1:0] exec_axis_q;
  logic [31:0] exec_a_q;
  logic [31:0] exec_b_q;
  logic        idx_pend;
  logic        home_pend;
  logic        sync_pend;
  logic [3:0]  map_mask;

  // Every cycle can take a command; its answer follows one cycle later
  assign cmd_ready_o = 1'b1;
  wire take = cmd_valid_i & cmd_ready_o;

  // Opcode decode
  wire [5:0] op = cmd_op_i;
  wire is_arc_rad = (op == mcec_pkg::OP_ARC1_RAD) | (op == mcec_pkg::OP_ARC2_RAD)
                  | (op == mcec_pkg::OP_ARC3_RAD);
  wire is_arc_end = (op == mcec_pkg::OP_ARC1_END) | (op == mcec_pkg::OP_ARC2_END)
                  | (op == mcec_pkg::OP_ARC3_END);
  wire is_line    = (op == mcec_pkg::OP_LINE2) | (op == mcec_pkg::OP_LINE3)
                  | (op == mcec_pkg::OP_LINE4);
  wire is_vec     = (op == mcec_pkg::OP_VEC_VEL) | (op == mcec_pkg::OP_VEC_ACC);
  wire is_move    = (op == mcec_pkg::OP_MOVE2) | (op == mcec_pkg::OP_MOVE3)
                  | (op == mcec_pkg::OP_MOVE4);
  wire is_map     = (op == mcec_pkg::OP_MAP_AXES);
  wire is_start   = (op == mcec_pkg::OP_START_MOVE) | (op == mcec_pkg::OP_START_LIST);
  wire is_append  = (op == mcec_pkg::OP_APPEND_LIST);
  wire is_path    = is_arc_rad | is_arc_end | is_line | is_move;
  wire is_coord   = is_path | is_vec | is_map | is_start | is_append;
  wire is_known   = (op <= mcec_pkg::OP_MOVE4);
  wire is_motion_par = (op == mcec_pkg::OP_SET_POS) | (op == mcec_pkg::OP_SET_VEL)
                     | (op == mcec_pkg::OP_SET_ACC) | (op == mcec_pkg::OP_SET_ACTUAL);
  wire is_ctrl_par   = (op == mcec_pkg::OP_SET_VEL) | (op == mcec_pkg::OP_SET_ACC)
                     | (op == mcec_pkg::OP_SET_JERK) | (op == mcec_pkg::OP_SET_CTRL_PAR);
  wire is_commit     = (op == mcec_pkg::OP_SINGLE_COMMIT)
                     | (op == mcec_pkg::OP_MULTI_COMMIT);

  // Argument checks against the motion bound and for zero or negative
  wire a_over  = over_bound(cmd_arg_a_i, bound_q);
  wire b_over  = over_bound(cmd_arg_b_i, bound_q);
  wire a_nonpos = non_pos(cmd_arg_a_i);

  // Cause bits
  wire c_ovf    = is_motion_par & a_over; // RQ11
  wire c_ctrl   = is_ctrl_par & cmd_arg_a_i[31]; // RQ12
  wire c_multi  = (op == mcec_pkg::OP_MULTI_COMMIT)
                & (cmd_arg_a_i == 32'h0000_0000); // RQ13
  wire c_drvclr = (op == mcec_pkg::OP_DRV_ALARM_CLR) & ax_active_i; // RQ14
  wire c_intr   = (op == mcec_pkg::OP_INTR_CMD) & ~intr_en_q; // RQ15
  wire c_mode   = (op == mcec_pkg::OP_SET_MODE) & ax_moving_i & ~ax_gear_i; // RQ16
  wire capt_busy = ax_capt_done_i | idx_pend | home_pend;
  wire c_idx    = (op == mcec_pkg::OP_ARM_INDEX) & capt_busy; // RQ17
  wire c_home   = (op == mcec_pkg::OP_ARM_HOME) & capt_busy; // RQ17
  wire c_ena    = (op == mcec_pkg::OP_AXIS_ENABLE) & ax_drv_alarm_i; // RQ18
  wire c_frozen = ((op == mcec_pkg::OP_ZERO_POS) & ax_moving_i)
                | (is_commit & ax_moving_i & frozen_change_i)
                | ((op == mcec_pkg::OP_SINGLE_COMMIT) & ax_jog_i & sync_pend); // RQ19
  wire c_crd    = (is_start & buf_exec_i) | (is_append & ~list_closed_i)
                | (is_path & seg_busy_i); // RQ20
  wire c_ptp    = is_move & (a_over | b_over); // RQ21
  wire c_full   = (is_path | is_vec) & buf_full_i; // RQ22

  wire [15:0] cause_new;
  assign cause_new = { c_full, 1'b0, c_ptp, c_crd, c_frozen, 1'b0, c_ena, c_home,
                       c_idx, c_mode, 1'b0, c_intr, c_drvclr, c_multi, c_ctrl,
                       c_ovf } & ~mcec_pkg::CAUSE_RSVD; // RQ10 RQ23

  // Specific parameter faults
  wire f_radius = is_arc_rad & ((cmd_arg_a_i == 32'h0000_0000) | a_over); // RQ2
  wire f_length = is_line & (a_nonpos | a_over); // RQ3
  wire f_vector = is_vec & (a_nonpos | a_over); // RQ4
  wire f_endpt  = is_arc_end & (((cmd_arg_a_i == 32'h0000_0000)
                & (cmd_arg_b_i == 32'h0000_0000)) | a_over | b_over); // RQ5
  wire [3:0] map_req = cmd_arg_a_i[3:0];
  wire f_map    = is_map & ((map_req == 4'h0) | (|(map_req & map_mask))); // RQ6
  wire f_param  = ~is_known | (~is_coord & ({{(32-AXIS_W){1'b0}}, cmd_axis_i}
                >= 32'(NUM_AXES))); // RQ7

  // Result priority: link fault, illegal, then specific faults
  logic [3:0] code;
  always_comb
  begin
    if (cmd_comm_err_i)
    begin
      code = mcec_pkg::RES_COMM; // RQ1
    end
    else if (|cause_new)
    begin
      code = mcec_pkg::RES_ILLEGAL; // RQ1
    end
    else if (f_radius)
    begin
      code = mcec_pkg::RES_RADIUS; // RQ2
    end
    else if (f_length)
    begin
      code = mcec_pkg::RES_LENGTH; // RQ3
    end
    else if (f_vector)
    begin
      code = mcec_pkg::RES_VECTOR; // RQ4
    end
    else if (f_endpt)
    begin
      code = mcec_pkg::RES_ENDPT; // RQ5
    end
    else if (f_map)
    begin
      code = mcec_pkg::RES_MAP; // RQ6
    end
    else if (f_param)
    begin
      code = mcec_pkg::RES_PARAM; // RQ7
    end
    else
    begin
      code = mcec_pkg::RES_OK; // RQ1
    end
  end

  wire accept  = take & (code == mcec_pkg::RES_OK); // RQ8
  wire illegal = take & (code == mcec_pkg::RES_ILLEGAL);
  wire cause_set_en = illegal & ~cmd_comm_err_i;

  mcec_track u_track
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .accept_i    (accept),
    .op_i        (op),
    .map_req_i   (map_req),
    .capt_done_i (ax_capt_done_i),
    .idx_pend_o  (idx_pend),
    .home_pend_o (home_pend),
    .sync_pend_o (sync_pend),
    .map_o       (map_mask)
  );

  // Register writes
  wire wr_ctrl  = rif.wr & (rif.addr == mcec_pkg::ADDR_CTRL) & rif.sel[0];
  wire wr_bound = rif.wr & (rif.addr == mcec_pkg::ADDR_BOUND);
  wire clr_cause = wr_ctrl & rif.wdata[mcec_pkg::CTRL_CLR_CAUSE];
  wire clr_sts   = wr_ctrl & rif.wdata[mcec_pkg::CTRL_CLR_STS];

  // New faults win over a clear in the same cycle
  assign cause_d = ((clr_cause ? 16'h0000 : cause_q)
                 | (cause_set_en ? cause_new : 16'h0000))
                 & ~mcec_pkg::CAUSE_RSVD; // RQ10 RQ23

  // Read mux
  wire [31:0] status_word = {20'h0_0000, last_code_q, axis_ill_q, 3'h0, crd_ill_q, 3'h0};
  always_comb
  begin
    unique case (rif.addr)
      mcec_pkg::ADDR_CAUSE:  rif.rdata = {16'h0000, cause_q}; // RQ10
      mcec_pkg::ADDR_CTRL:   rif.rdata = {31'h0000_0000, intr_en_q};
      mcec_pkg::ADDR_STATUS: rif.rdata = status_word;
      mcec_pkg::ADDR_BOUND:  rif.rdata = bound_q;
      mcec_pkg::ADDR_MAP:    rif.rdata = {28'h000_0000, map_mask};
      default:               rif.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cause_q   <= mcec_pkg::CAUSE_RST;
      intr_en_q <= mcec_pkg::INTR_EN_RST;
      bound_q   <= mcec_pkg::BOUND_RST;
    end
    else
    begin
      cause_q   <= cause_d;
      intr_en_q <= wr_ctrl ? rif.wdata[mcec_pkg::CTRL_INTR_EN] : intr_en_q;
      bound_q   <= wr_bound ? merge(bound_q, rif.wdata, rif.sel) : bound_q;
    end
  end

  // Illegal status flags, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crd_ill_q   <= 1'b0;
      axis_ill_q  <= 1'b0;
      last_code_q <= mcec_pkg::RES_OK;
    end
    else
    begin
      crd_ill_q   <= (illegal & is_coord) | (crd_ill_q & ~clr_sts); // RQ9
      axis_ill_q  <= (illegal & ~is_coord) | (axis_ill_q & ~clr_sts); // RQ9
      last_code_q <= take ? code : last_code_q;
    end
  end

  // Answer every command, forward accepted commands only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rsp_valid_q  <= 1'b0;
      rsp_code_q   <= mcec_pkg::RES_OK;
      exec_valid_q <= 1'b0;
      exec_op_q    <= 6'h00;
      exec_axis_q  <= '0;
      exec_a_q     <= 32'h0000_0000;
      exec_b_q     <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid_q  <= take; // RQ1
      rsp_code_q   <= take ? code : rsp_code_q;
      exec_valid_q <= accept; // RQ8 RQ22
      exec_op_q    <= accept ? op : exec_op_q;
      exec_axis_q  <= accept ? cmd_axis_i : exec_axis_q;
      exec_a_q     <= accept ? cmd_arg_a_i : exec_a_q;
      exec_b_q     <= accept ? cmd_arg_b_i : exec_b_q;
    end
  end

  assign rsp_valid_o    = rsp_valid_q;
  assign rsp_code_o     = rsp_code_q;
  assign exec_valid_o   = exec_valid_q;
  assign exec_op_o      = exec_op_q;
  assign exec_axis_o    = exec_axis_q;
  assign exec_arg_a_o   = exec_a_q;
  assign exec_arg_b_o   = exec_b_q;
  assign crd_illegal_o  = crd_ill_q;
  assign axis_illegal_o = axis_ill_q;
  assign intr_enable_o  = intr_en_q;

endmodule // mcec_checker_top
`default_nettype wire

// *** rtl/mcec_track.sv ***
// Remembers armed captures, pending position sync and axis mapping
`timescale 1ns/1ps
`default_nettype none
module mcec_track
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        accept_i,
  input  wire logic [5:0]  op_i,
  input  wire logic [3:0]  map_req_i,
  input  wire logic        capt_done_i,
  output logic             idx_pend_o,
  output logic             home_pend_o,
  output logic             sync_pend_o,
  output logic      [3:0]  map_o
);
  wire acc_idx  = accept_i & (op_i == mcec_pkg::OP_ARM_INDEX);
  wire acc_home = accept_i & (op_i == mcec_pkg::OP_ARM_HOME);
  wire acc_sync = accept_i & (op_i == mcec_pkg::OP_SYNC_POS);
  wire acc_cmt  = accept_i & (op_i == mcec_pkg::OP_SINGLE_COMMIT);
  wire acc_map  = accept_i & (op_i == mcec_pkg::OP_MAP_AXES);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_pend_o  <= 1'b0;
      home_pend_o <= 1'b0;
      sync_pend_o <= 1'b0;
      map_o       <= mcec_pkg::MAP_RST;
    end
    else
    begin
      // Arming wins over a capture in the same cycle
      idx_pend_o  <= acc_idx | (idx_pend_o & ~capt_done_i);
      home_pend_o <= acc_home | (home_pend_o & ~capt_done_i);
      sync_pend_o <= acc_sync | (sync_pend_o & ~acc_cmt);
      map_o       <= acc_map ? (map_o | map_req_i) : map_o;
    end
  end
endmodule // mcec_track
`default_nettype wire

// *** rtl/mcec_wb_slave.sv ***
// Classic Wishbone slave front end with a registered ack after one wait state
`timescale 1ns/1ps
`default_nettype none
module mcec_wb_slave
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  mcec_reg_if.bus          rif
);
  logic        ack_q;
  logic [31:0] dat_q;
  wire         req = wb_cyc_i & wb_stb_i;

  // Write lands on the edge where the master sees ack
  assign rif.wr    = req & wb_we_i & ack_q;
  assign rif.addr  = wb_adr_i;
  assign rif.wdata = wb_dat_i;
  assign rif.sel   = wb_sel_i;
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      dat_q <= (req & ~ack_q & ~wb_we_i) ? rif.rdata : 32'h0000_0000;
    end
  end
endmodule // mcec_wb_slave
`default_nettype wire
